// *** sscr_pkg.sv ***
// Constants and types for the serial and sniff configuration register set
package sscr_pkg;

  // Clock rate and derived timing
  localparam int CLK_HZ           = 125_000_000;
  localparam int CLK_KHZ          = CLK_HZ / 1000;
  localparam int ESC_UNIT_MS      = 20;                       // Escape window unit, ms
  localparam int ESC_UNIT_CYCLES  = ESC_UNIT_MS * CLK_KHZ;    // Cycles per escape unit
  localparam int SNIFF_SLOT_US    = 625;                      // Sniff slot length, us

  // Serial rates in bit/s and their bit periods in clock cycles (rounded)
  localparam int BAUD_9600        = 9600;
  localparam int BAUD_19200       = 19200;
  localparam int BAUD_38400       = 38400;
  localparam int BAUD_57600       = 57600;
  localparam int BAUD_115200      = 115200;
  localparam logic [15:0] BIT_9600   = 16'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [15:0] BIT_19200  = 16'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
  localparam logic [15:0] BIT_38400  = 16'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);
  localparam logic [15:0] BIT_57600  = 16'((CLK_HZ + BAUD_57600 / 2) / BAUD_57600);
  localparam logic [15:0] BIT_115200 = 16'((CLK_HZ + BAUD_115200 / 2) / BAUD_115200);

  // Register count and storage indices (also the non-volatile word addresses)
  localparam int         NUM_REGS        = 12;
  localparam logic [3:0] IDX_RATE        = 4'h0;
  localparam logic [3:0] IDX_CHAR_LEN    = 4'h1;
  localparam logic [3:0] IDX_PARITY      = 4'h2;
  localparam logic [3:0] IDX_STOP        = 4'h3;
  localparam logic [3:0] IDX_ESCAPE      = 4'h4;
  localparam logic [3:0] IDX_HANDSHAKE   = 4'h5;
  localparam logic [3:0] IDX_PROFILE     = 4'h6;
  localparam logic [3:0] IDX_POWER       = 4'h7;
  localparam logic [3:0] IDX_SNIFF_MAX   = 4'h8;
  localparam logic [3:0] IDX_SNIFF_MIN   = 4'h9;
  localparam logic [3:0] IDX_SNIFF_ATT   = 4'ha;
  localparam logic [3:0] IDX_SNIFF_EXTRA = 4'hb;

  // Register numbers as carried by the set and query commands
  localparam logic [15:0] NUM_RATE        = 16'h00d2;  // 210
  localparam logic [15:0] NUM_ESCAPE_LAST = 16'h00d7;  // 215
  localparam logic [15:0] NUM_PROFILE     = 16'h00dc;  // 220
  localparam logic [15:0] NUM_POWER       = 16'h00e6;  // 230
  localparam logic [15:0] NUM_SNIFF_LAST  = 16'h00ea;  // 234

  // Reset values
  localparam logic [15:0] RST_RATE        = 16'h0008;
  localparam logic [15:0] RST_CHAR_LEN    = 16'h0008;
  localparam logic [15:0] RST_PARITY      = 16'h0001;
  localparam logic [15:0] RST_STOP        = 16'h0001;
  localparam logic [15:0] RST_ESCAPE      = 16'h0032;
  localparam logic [15:0] RST_HANDSHAKE   = 16'h0001;
  localparam logic [15:0] RST_PROFILE     = 16'h0001;
  localparam logic [15:0] RST_POWER       = 16'h0000;
  localparam logic [15:0] RST_SNIFF_MAX   = 16'h0320;
  localparam logic [15:0] RST_SNIFF_MIN   = 16'h0050;
  localparam logic [15:0] RST_SNIFF_ATT   = 16'h0008;
  localparam logic [15:0] RST_SNIFF_EXTRA = 16'h0008;

  // Field encodings
  localparam logic [15:0] RATE_MIN        = 16'h0004;
  localparam logic [15:0] RATE_9600       = 16'h0004;
  localparam logic [15:0] RATE_19200      = 16'h0005;
  localparam logic [15:0] RATE_38400      = 16'h0006;
  localparam logic [15:0] RATE_57600      = 16'h0007;
  localparam logic [15:0] RATE_115200     = 16'h0008;
  localparam logic [15:0] CHAR_LEN_8      = 16'h0008;
  localparam logic [15:0] PARITY_NONE     = 16'h0001;
  localparam logic [15:0] PARITY_EVEN     = 16'h0002;
  localparam logic [15:0] PARITY_ODD      = 16'h0003;
  localparam logic [15:0] STOP_ONE        = 16'h0001;
  localparam logic [15:0] STOP_TWO        = 16'h0002;
  localparam logic [15:0] ESCAPE_MIN      = 16'h0001;
  localparam logic [15:0] ESCAPE_MAX      = 16'h00ff;
  localparam logic [15:0] HANDSHAKE_MAX   = 16'h0001;
  localparam logic [15:0] PROFILE_SERIAL  = 16'h0001;
  localparam logic [15:0] PROFILE_DIALUP  = 16'h0002;
  localparam logic [15:0] POWER_USER_SNIFF = 16'h0004;

  // Control sequencer states
  typedef enum logic [2:0] {
    SSCR_BOOT_REQ,
    SSCR_BOOT_CAP,
    SSCR_APPLY,
    SSCR_RUN,
    SSCR_SAVE
  } sscr_state_e;

  // Whole state of the register block
  typedef struct packed {
    sscr_state_e       st;
    logic [3:0]        idx;
    logic [11:0][15:0] regs;
    logic [15:0]       bit_cycles;
    logic              par_en;
    logic              par_odd;
    logic              two_stop;
    logic              fmt_pend;
    logic              flow_on;
    logic [29:0]       esc_cycles;
    logic [15:0]       rdata;
    logic              ack;
    logic              err;
    logic              drop;
    logic              nvm_rd;
    logic              nvm_wr;
    logic [3:0]        nvm_addr;
    logic [15:0]       nvm_wdata;
  } sscr_state_s;

endpackage : sscr_pkg

// *** sscr_regs.sv ***
// Serial format, escape timing, flow control, profile and sniff configuration registers
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Rate code 4..8 selects 9600..115200 bit/s
// - Only eight-bit characters, code 8
// - Parity code: 1 none, 2 even, 3 odd
// - Stop code 1 or 2 stop bits
// - Escape window in 20 ms units, 1..255
// - Handshake register 0 off, 1 on
// - New handshake setting applies at return online
// - Profile 1 serial port, 2 dial-up
// - Low-power modes 0..4, 4 uses sniff registers
// - Sniff max interval is wake period, 625 us
// - Sniff timeout counts extra listening slots
// - Local radio-setting change drops the link
// - Remote changes never drop the link
// - Reply in old format, then switch format
// - Load from non-volatile store, save on command
module sscr_regs #(
  parameter int ESC_UNIT_CYCLES = sscr_pkg::ESC_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Decoded commands from the text parser
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic        cmd_remote,
  input  wire logic        cmd_save,
  input  wire logic        return_online_command,
  input  wire logic [15:0] cmd_reg_num,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_busy,
  output logic             cmd_ack,
  output logic             cmd_err,
  output logic [15:0]      cmd_rdata,
  // Reply transmission status from the serial port
  input  wire logic        tx_reply_done,
  // Non-volatile configuration store
  output logic             nvm_rd_en,
  output logic             nvm_wr_en,
  output logic [3:0]       nvm_addr,
  output logic [15:0]      nvm_wdata,
  input  wire logic [15:0] nvm_rdata,
  // Serial format in force
  output logic [15:0]      uart_bit_cycles,
  output logic [3:0]       uart_data_bits,
  output logic             uart_parity_en,
  output logic             uart_parity_odd,
  output logic             uart_two_stop,
  output logic [29:0]      escape_window_cycles,
  output logic             rts_cts_enable,
  // Radio configuration
  output logic [7:0]       profile_code,
  output logic [7:0]       power_mode,
  output logic [15:0]      sniff_interval_slots,
  output logic [15:0]      sniff_offset_slots,
  output logic [15:0]      sniff_attempt_slots,
  output logic [15:0]      sniff_extra_slots,
  output logic             link_drop
);

  sscr_pkg::sscr_state_s q;
  sscr_pkg::sscr_state_s n;

  logic        hit;
  logic [3:0]  hit_idx;
  logic        val_ok;
  logic [15:0] boot_val;

  // Map a command register number onto a storage index
  function automatic logic [4:0] lookup(input logic [15:0] num);
    logic [4:0] r;
    r = 5'h00;
    if (num >= sscr_pkg::NUM_RATE && num <= sscr_pkg::NUM_ESCAPE_LAST) begin
      r = {1'b1, 4'(num - sscr_pkg::NUM_RATE)};
    end else if (num == sscr_pkg::NUM_PROFILE) begin
      r = {1'b1, sscr_pkg::IDX_PROFILE};
    end else if (num >= sscr_pkg::NUM_POWER && num <= sscr_pkg::NUM_SNIFF_LAST) begin
      r = {1'b1, 4'(num - sscr_pkg::NUM_POWER + 16'(sscr_pkg::IDX_POWER))};
    end
    return r;
  endfunction : lookup

  function automatic logic legal(input logic [3:0] i, input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    unique case (i)
      sscr_pkg::IDX_RATE:      ok = v >= sscr_pkg::RATE_MIN && v <= sscr_pkg::RATE_115200;
      sscr_pkg::IDX_CHAR_LEN:  ok = v == sscr_pkg::CHAR_LEN_8;
      sscr_pkg::IDX_PARITY:    ok = v >= sscr_pkg::PARITY_NONE && v <= sscr_pkg::PARITY_ODD;
      sscr_pkg::IDX_STOP:      ok = v == sscr_pkg::STOP_ONE || v == sscr_pkg::STOP_TWO;
      sscr_pkg::IDX_ESCAPE:    ok = v >= sscr_pkg::ESCAPE_MIN && v <= sscr_pkg::ESCAPE_MAX;
      sscr_pkg::IDX_HANDSHAKE: ok = v <= sscr_pkg::HANDSHAKE_MAX;
      sscr_pkg::IDX_PROFILE:   ok = v == sscr_pkg::PROFILE_SERIAL ||
                                    v == sscr_pkg::PROFILE_DIALUP;
      sscr_pkg::IDX_POWER:     ok = v <= sscr_pkg::POWER_USER_SNIFF;
      // Sniff slot counts take any 16-bit value; the host keeps their relations
      default:                 ok = 1'b1;
    endcase
    return ok;
  endfunction : legal

  // bit period for each rate code
  function automatic logic [15:0] rate_cycles(input logic [15:0] code);
    logic [15:0] c;
    c = sscr_pkg::BIT_115200;
    unique case (code)
      sscr_pkg::RATE_9600:  c = sscr_pkg::BIT_9600;
      sscr_pkg::RATE_19200: c = sscr_pkg::BIT_19200;
      sscr_pkg::RATE_38400: c = sscr_pkg::BIT_38400;
      sscr_pkg::RATE_57600: c = sscr_pkg::BIT_57600;
      default:              c = sscr_pkg::BIT_115200;
    endcase
    return c;
  endfunction : rate_cycles

  // Reset value of a register, also used when a stored word is corrupt
  function automatic logic [15:0] reset_val(input logic [3:0] i);
    logic [15:0] v;
    v = 16'h0000;
    unique case (i)
      sscr_pkg::IDX_RATE:        v = sscr_pkg::RST_RATE;
      sscr_pkg::IDX_CHAR_LEN:    v = sscr_pkg::RST_CHAR_LEN;
      sscr_pkg::IDX_PARITY:      v = sscr_pkg::RST_PARITY;
      sscr_pkg::IDX_STOP:        v = sscr_pkg::RST_STOP;
      sscr_pkg::IDX_ESCAPE:      v = sscr_pkg::RST_ESCAPE;
      sscr_pkg::IDX_HANDSHAKE:   v = sscr_pkg::RST_HANDSHAKE;
      sscr_pkg::IDX_PROFILE:     v = sscr_pkg::RST_PROFILE;
      sscr_pkg::IDX_POWER:       v = sscr_pkg::RST_POWER;
      sscr_pkg::IDX_SNIFF_MAX:   v = sscr_pkg::RST_SNIFF_MAX;
      sscr_pkg::IDX_SNIFF_MIN:   v = sscr_pkg::RST_SNIFF_MIN;
      sscr_pkg::IDX_SNIFF_ATT:   v = sscr_pkg::RST_SNIFF_ATT;
      default:                   v = sscr_pkg::RST_SNIFF_EXTRA;
    endcase
    return v;
  endfunction : reset_val

  // Register number decode for the pending command
  always_comb begin
    {hit, hit_idx} = lookup(cmd_reg_num);
    val_ok   = legal(hit_idx, cmd_wdata);
    boot_val = legal(q.idx, nvm_rdata) ? nvm_rdata : reset_val(q.idx);
  end

  // Next-state logic of the whole block
  always_comb begin
    n        = q;
    n.ack    = 1'b0;
    n.err    = 1'b0;
    n.drop   = 1'b0;
    n.nvm_rd = 1'b0;
    n.nvm_wr = 1'b0;
    unique case (q.st)
      // power-up load, one word per two cycles
      sscr_pkg::SSCR_BOOT_REQ: begin
        n.nvm_rd   = 1'b1;
        n.nvm_addr = q.idx;
        n.st       = sscr_pkg::SSCR_BOOT_CAP;
      end
      sscr_pkg::SSCR_BOOT_CAP: begin
        n.regs[q.idx] = boot_val;
        if (q.idx == 4'(sscr_pkg::NUM_REGS - 1)) begin
          n.st = sscr_pkg::SSCR_APPLY;
        end else begin
          n.idx = q.idx + 4'h1;
          n.st  = sscr_pkg::SSCR_BOOT_REQ;
        end
      end
      // Loaded format and handshake take effect at once
      sscr_pkg::SSCR_APPLY: begin
        n.bit_cycles = rate_cycles(q.regs[sscr_pkg::IDX_RATE]);
        n.par_en     = q.regs[sscr_pkg::IDX_PARITY] != sscr_pkg::PARITY_NONE;
        n.par_odd    = q.regs[sscr_pkg::IDX_PARITY] == sscr_pkg::PARITY_ODD;
        n.two_stop   = q.regs[sscr_pkg::IDX_STOP] == sscr_pkg::STOP_TWO;
        n.flow_on    = q.regs[sscr_pkg::IDX_HANDSHAKE][0];
        n.fmt_pend   = 1'b0;
        n.idx        = 4'h0;
        n.st         = sscr_pkg::SSCR_RUN;
      end
      // save working copy to the store
      sscr_pkg::SSCR_SAVE: begin
        n.nvm_wr    = 1'b1;
        n.nvm_addr  = q.idx;
        n.nvm_wdata = q.regs[q.idx];
        if (q.idx == 4'(sscr_pkg::NUM_REGS - 1)) begin
          n.idx = 4'h0;
          n.ack = 1'b1;
          n.st  = sscr_pkg::SSCR_RUN;
        end else begin
          n.idx = q.idx + 4'h1;
        end
      end
      default: begin
        // switch format once the reply left
        if (tx_reply_done && q.fmt_pend) begin
          n.bit_cycles = rate_cycles(q.regs[sscr_pkg::IDX_RATE]);
          n.par_en     = q.regs[sscr_pkg::IDX_PARITY] != sscr_pkg::PARITY_NONE;
          n.par_odd    = q.regs[sscr_pkg::IDX_PARITY] == sscr_pkg::PARITY_ODD;
          n.two_stop   = q.regs[sscr_pkg::IDX_STOP] == sscr_pkg::STOP_TWO;
          n.fmt_pend   = 1'b0;
        end
        // One command per cycle, save first, then online, write, query
        if (cmd_save) begin
          n.idx = 4'h0;
          n.st  = sscr_pkg::SSCR_SAVE;
        end else if (return_online_command) begin
          n.flow_on = q.regs[sscr_pkg::IDX_HANDSHAKE][0];
          n.ack     = 1'b1;
        end else if (cmd_wr) begin
          if (!hit || !val_ok) begin
            n.err = 1'b1;
          end else begin
            n.regs[hit_idx] = cmd_wdata;
            n.ack           = 1'b1;
            if (hit_idx >= sscr_pkg::IDX_PROFILE && !cmd_remote &&
                q.regs[hit_idx] != cmd_wdata) begin
              n.drop = 1'b1;
            end
            if (hit_idx <= sscr_pkg::IDX_STOP) begin
              n.fmt_pend = 1'b1;
            end
          end
        end else if (cmd_rd) begin
          if (hit) begin
            n.rdata = q.regs[hit_idx];
            n.ack   = 1'b1;
          end else begin
            n.err = 1'b1;
          end
        end
      end
    endcase
    // escape window follows the register at once
    n.esc_cycles = 30'(n.regs[sscr_pkg::IDX_ESCAPE][7:0] * 30'(ESC_UNIT_CYCLES));
  end

  // State register; reset loads defaults and starts the store load
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q            <= '0;
      q.st         <= sscr_pkg::SSCR_BOOT_REQ;
      q.bit_cycles <= sscr_pkg::BIT_115200;
      q.flow_on    <= sscr_pkg::RST_HANDSHAKE[0];
      q.esc_cycles <= 30'(sscr_pkg::RST_ESCAPE[7:0] * 30'(ESC_UNIT_CYCLES));
      for (int i = 0; i < sscr_pkg::NUM_REGS; i++) begin
        q.regs[i] <= reset_val(4'(i));
      end
    end else begin
      q <= n;
    end
  end

  // Command answers; busy while loading or saving so commands are not lost
  assign cmd_busy  = q.st != sscr_pkg::SSCR_RUN;
  assign cmd_ack   = q.ack;
  assign cmd_err   = q.err;
  assign cmd_rdata = q.rdata;

  // Store port
  assign nvm_rd_en = q.nvm_rd;
  assign nvm_wr_en = q.nvm_wr;
  assign nvm_addr  = q.nvm_addr;
  assign nvm_wdata = q.nvm_wdata;

  // Serial format in force; data length is fixed at eight
  // eight data bits
  assign uart_data_bits       = 4'h8;
  assign uart_bit_cycles      = q.bit_cycles;
  assign uart_parity_en       = q.par_en;
  assign uart_parity_odd      = q.par_odd;
  assign uart_two_stop        = q.two_stop;
  assign escape_window_cycles = q.esc_cycles;
  assign rts_cts_enable       = q.flow_on;

  // Radio configuration straight from the working registers, then the registered link drop pulse
  // profile code out
  assign profile_code         = q.regs[sscr_pkg::IDX_PROFILE][7:0];
  assign power_mode           = q.regs[sscr_pkg::IDX_POWER][7:0];
  assign sniff_interval_slots = q.regs[sscr_pkg::IDX_SNIFF_MAX];
  assign sniff_offset_slots   = q.regs[sscr_pkg::IDX_SNIFF_MIN];
  assign sniff_attempt_slots  = q.regs[sscr_pkg::IDX_SNIFF_ATT];
  assign sniff_extra_slots    = q.regs[sscr_pkg::IDX_SNIFF_EXTRA];
  assign link_drop            = q.drop;

endmodule : sscr_regs
`default_nettype wire

// *** sscr_regs_sva.sv ***
// Property checker for the serial and sniff configuration registers
`timescale 1ns/1ps
`default_nettype none
module sscr_regs_sva #(
  parameter int ESC_UNIT_CYCLES = 10
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Command port
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire logic        cmd_remote,
  input wire logic        cmd_save,
  input wire logic        return_online_command,
  input wire logic [15:0] cmd_reg_num,
  input wire logic [15:0] cmd_wdata,
  input wire logic        cmd_busy,
  input wire logic        cmd_ack,
  input wire logic        cmd_err,
  input wire logic [15:0] cmd_rdata,
  input wire logic        tx_reply_done,
  // Store, format and radio outputs
  input wire logic        nvm_wr_en,
  input wire logic [3:0]  nvm_addr,
  input wire logic [15:0] uart_bit_cycles,
  input wire logic [3:0]  uart_data_bits,
  input wire logic [29:0] escape_window_cycles,
  input wire logic        rts_cts_enable,
  input wire logic [15:0] sniff_interval_slots,
  input wire logic        link_drop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A write or query taken with no higher-priority strobe beside it
  logic only_wr;
  logic only_rd;
  assign only_wr = cmd_wr && !cmd_busy && !cmd_save && !return_online_command;
  assign only_rd = cmd_rd && !cmd_busy && !cmd_save && !return_online_command && !cmd_wr;
  // Twelve store writes, first and last word pinned
  sequence save_burst;
    (nvm_wr_en && nvm_addr == 4'h0) ##11 (nvm_wr_en && nvm_addr == 4'hb && cmd_ack);
  endsequence
  ack_err_excl_a: assert property (!(cmd_ack && cmd_err))
    else $error("ack and error together");
  busy_no_err_a: assert property (cmd_busy |=> !cmd_err)
    else $error("error answer while busy");
  rd_answer_a: assert property (only_rd |=> cmd_ack ^ cmd_err)
    else $error("query not answered");
  rd_interval_a: assert property (only_rd && cmd_reg_num == 16'h00e7
    |=> cmd_ack && cmd_rdata == sniff_interval_slots) else $error("interval query wrong");
  bad_rate_a: assert property (only_wr && cmd_reg_num == 16'h00d2
    && !(cmd_wdata inside {[16'h0004:16'h0008]}) |=> cmd_err && !cmd_ack)
    else $error("illegal rate accepted");
  esc_window_a: assert property (only_wr && cmd_reg_num == 16'h00d6
    && cmd_wdata inside {[16'h0001:16'h00ff]}
    |=> escape_window_cycles == 30'($past(cmd_wdata)) * 30'(ESC_UNIT_CYCLES))
    else $error("escape window wrong");
  fmt_hold_a: assert property ($changed(uart_bit_cycles) && !$past(cmd_busy)
    |-> $past(tx_reply_done)) else $error("rate changed without reply done");
  flow_hold_a: assert property ($changed(rts_cts_enable) && !$past(cmd_busy)
    |-> $past(return_online_command)) else $error("handshake changed early");
  drop_local_a: assert property (link_drop
    |-> cmd_ack && $past(cmd_wr) && !$past(cmd_remote)) else $error("bad link drop");
  drop_sniff_a: assert property (only_wr && !cmd_remote && cmd_reg_num == 16'h00e7
    && cmd_wdata != sniff_interval_slots |=> link_drop) else $error("no link drop");
  save_seq_a: assert property (cmd_save && !cmd_busy |=> ##1 save_burst)
    else $error("save sequence wrong");
  width_fixed_a: assert property (uart_data_bits == 4'h8)
    else $error("data length not eight");
endmodule : sscr_regs_sva
bind sscr_regs sscr_regs_sva #(.ESC_UNIT_CYCLES(ESC_UNIT_CYCLES)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_remote(cmd_remote), .cmd_save(cmd_save),
  .return_online_command(return_online_command), .cmd_reg_num(cmd_reg_num),
  .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
  .cmd_rdata(cmd_rdata), .tx_reply_done(tx_reply_done), .nvm_wr_en(nvm_wr_en),
  .nvm_addr(nvm_addr), .uart_bit_cycles(uart_bit_cycles), .uart_data_bits(uart_data_bits),
  .escape_window_cycles(escape_window_cycles), .rts_cts_enable(rts_cts_enable),
  .sniff_interval_slots(sniff_interval_slots), .link_drop(link_drop));
`default_nettype wire

// *** sscr_nvm_model.sv ***
// Behavioural non-volatile store facing the register block
`timescale 1ns/1ps
`default_nettype none
module sscr_nvm_model (
  // Clock
  input wire logic        sys_clk,
  // Store port
  input wire logic        nvm_rd_en,
  input wire logic        nvm_wr_en,
  input wire logic [3:0]  nvm_addr,
  input wire logic [15:0] nvm_wdata,
  output logic [15:0]     nvm_rdata
);
  logic [15:0] mem [12];
  // Stored image: parity even, rate word corrupted to test boot repair
  initial begin
    mem = '{16'h0009, 16'h0008, 16'h0002, 16'h0001, 16'h0032, 16'h0001,
            16'h0001, 16'h0000, 16'h0320, 16'h0050, 16'h0008, 16'h0008};
  end
  // load and save
  // Word stands only while the read strobe does; inverse otherwise catches a late sample
  assign nvm_rdata = nvm_rd_en ? mem[nvm_addr] : ~mem[nvm_addr];
  always @(posedge sys_clk) begin
    if (nvm_wr_en)
      mem[nvm_addr] <= nvm_wdata;
  end
endmodule : sscr_nvm_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int ESC = 10;
  localparam int BAD_I [10] = '{0, 0, 1, 2, 3, 4, 4, 5, 6, 7};
  localparam logic [15:0] BAD_V [10] = '{16'h0003, 16'h0009, 16'h0007, 16'h0000,
    16'h0003, 16'h0000, 16'h0100, 16'h0002, 16'h0003, 16'h0005};
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_wr = 1'b0;
  logic        cmd_rd = 1'b0;
  logic        cmd_remote = 1'b0;
  logic        cmd_save = 1'b0;
  logic        return_online_command = 1'b0;
  logic        tx_reply_done = 1'b0;
  logic [15:0] cmd_reg_num = 16'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        cmd_busy, cmd_ack, cmd_err, nvm_rd_en, nvm_wr_en, link_drop;
  logic        par_en, par_odd, two_stop, rts;
  logic [3:0]  nvm_addr, data_bits;
  logic [7:0]  profile_code, power_mode;
  logic [15:0] cmd_rdata, nvm_wdata, nvm_rdata, bit_cycles, s_int, s_off, s_att, s_ext;
  logic [29:0] esc_cycles;
  logic        got_ack, got_err, got_drop;
  logic [15:0] got_rd, tmax;
  logic [15:0] shadow [12];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  // Design and store
  sscr_regs #(.ESC_UNIT_CYCLES(ESC)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_remote(cmd_remote), .cmd_save(cmd_save),
    .return_online_command(return_online_command), .cmd_reg_num(cmd_reg_num),
    .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
    .cmd_rdata(cmd_rdata), .tx_reply_done(tx_reply_done), .nvm_rd_en(nvm_rd_en),
    .nvm_wr_en(nvm_wr_en), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata), .uart_bit_cycles(bit_cycles), .uart_data_bits(data_bits),
    .uart_parity_en(par_en), .uart_parity_odd(par_odd), .uart_two_stop(two_stop),
    .escape_window_cycles(esc_cycles), .rts_cts_enable(rts), .profile_code(profile_code),
    .power_mode(power_mode), .sniff_interval_slots(s_int), .sniff_offset_slots(s_off),
    .sniff_attempt_slots(s_att), .sniff_extra_slots(s_ext), .link_drop(link_drop));
  sscr_nvm_model u_nvm (.sys_clk(sys_clk), .nvm_rd_en(nvm_rd_en), .nvm_wr_en(nvm_wr_en),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));

  // Clock and hang guard
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] reg_num(input int i);
    if (i < 6)
      return 16'h00d2 + 16'(i);
    if (i == 6)
      return 16'h00dc;
    return 16'h00df + 16'(i);
  endfunction : reg_num

  function automatic logic [15:0] exp_bits(input logic [15:0] c);
    case (c)
      16'h0004: return sscr_pkg::BIT_9600;
      16'h0005: return sscr_pkg::BIT_19200;
      16'h0006: return sscr_pkg::BIT_38400;
      16'h0007: return sscr_pkg::BIT_57600;
      default:  return sscr_pkg::BIT_115200;
    endcase
  endfunction : exp_bits

  // One command: strobe for one edge, answer sampled after the next
  task automatic cmd(input logic w, input logic r, input logic rem, input logic [15:0] num,
                     input logic [15:0] d);
    @(posedge sys_clk);
    cmd_wr <= w;
    cmd_rd <= r;
    cmd_remote <= rem;
    cmd_reg_num <= num;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1;
    got_ack = cmd_ack;
    got_err = cmd_err;
    got_drop = link_drop;
    got_rd = cmd_rdata;
  endtask : cmd

  task automatic pulse_ctl(input logic done, input logic online);
    @(posedge sys_clk);
    tx_reply_done <= done;
    return_online_command <= online;
    @(posedge sys_clk);
    tx_reply_done <= 1'b0;
    return_online_command <= 1'b0;
    #1;
  endtask : pulse_ctl

  task automatic wr_ok(input int i, input logic [15:0] v, input logic rem);
    logic dr;
    dr = !rem && i >= 6 && v !== shadow[i];
    cmd(1'b1, 1'b0, rem, reg_num(i), v);
    chk(got_ack, 1'b1);
    chk(got_drop, dr);
    shadow[i] = v;
  endtask : wr_ok

  task automatic fmt_chk();
    chk(bit_cycles, exp_bits(shadow[0]));
    chk({par_en, par_odd}, {shadow[2] != 16'h0001, shadow[2] == 16'h0003});
    chk({two_stop, data_bits}, {shadow[3] == 16'h0002, 4'h8});
  endtask : fmt_chk

  // Format change takes effect only after the reply has gone out
  task automatic fmt_step(input int i, input logic [15:0] v);
    logic [15:0] old;
    old = shadow[i];
    wr_ok(i, v, 1'b0);
    shadow[i] = old;
    fmt_chk();
    shadow[i] = v;
    pulse_ctl(1'b1, 1'b0);
    fmt_chk();
  endtask : fmt_step

  task automatic rd_all();
    for (int i = 0; i < 12; i++) begin
      cmd(1'b0, 1'b1, 1'b0, reg_num(i), 16'h0000);
      chk({got_ack, got_rd}, {1'b1, shadow[i]});
    end
  endtask : rd_all

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    int k;
    void'($urandom(32'hf369));
    shadow = '{16'h0008, 16'h0008, 16'h0002, 16'h0001, 16'h0032, 16'h0001,
               16'h0001, 16'h0000, 16'h0320, 16'h0050, 16'h0008, 16'h0008};
    @(posedge sys_clk);
    #1;
    chk({cmd_busy, rts, bit_cycles}, {2'b11, 16'h043d});
    @(posedge sys_clk);
    rst_n <= 1'b1;
    k = 0;
    while (cmd_busy !== 1'b0 && k < 60) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    // stored image loaded, corrupt rate word repaired
    fmt_chk();
    rd_all();
    $display("test boot done");
    for (int c = 4; c <= 8; c++)
      fmt_step(0, 16'(c));
    for (int c = 3; c >= 1; c--)
      fmt_step(2, 16'(c));
    fmt_step(3, 16'h0002);
    fmt_step(3, 16'h0001);
    fmt_step(0, 16'(4 + $urandom % 5));
    wr_ok(1, 16'h0008, 1'b0);
    $display("test format done");
    // illegal values and unknown numbers refused
    for (int j = 0; j < 10; j++) begin
      cmd(1'b1, 1'b0, 1'b0, reg_num(BAD_I[j]), BAD_V[j]);
      chk({got_ack, got_err}, 2'b01);
    end
    cmd(1'b1, 1'b0, 1'b0, 16'h00d8, 16'h0001);
    chk(got_err, 1'b1);
    cmd(1'b0, 1'b1, 1'b0, 16'h00dd, 16'h0000);
    chk(got_err, 1'b1);
    rd_all();
    $display("test refuse done");
    for (int j = 0; j < 4; j++) begin
      wr_ok(4, (j == 0) ? 16'h0001 : (j == 1) ? 16'h00ff : 16'(1 + $urandom % 255), 1'b0);
      chk(esc_cycles, 30'(shadow[4]) * 30'(ESC));
    end
    for (int j = 0; j < 2; j++) begin
      wr_ok(5, 16'(j), 1'b0);
      chk(rts, j == 0);
      pulse_ctl(1'b0, 1'b1);
      chk(rts, j == 1);
    end
    $display("test escape and flow done");
    wr_ok(6, 16'h0002, 1'b0);
    wr_ok(6, 16'h0002, 1'b0);
    chk(profile_code, 8'h02);
    for (int m = 0; m < 5; m++) begin
      wr_ok(7, 16'(m), 1'b0);
      chk(power_mode, 8'(m));
    end
    // host keeps offset and attempt inside the period
    for (int j = 0; j < 2; j++) begin
      tmax = 16'(100 + $urandom % 1000);
      wr_ok(8, tmax, j == 0);
      wr_ok(9, 16'($urandom % (tmax - 16'h0001)), j == 0);
      wr_ok(10, 16'($urandom % (tmax / 16'h0002)), j == 0);
      wr_ok(11, 16'($urandom % 64), j == 0);
      chk({s_int, s_off, s_att, s_ext}, {shadow[8], shadow[9], shadow[10], shadow[11]});
    end
    $display("test radio done");
    wr_ok(2, 16'h0003, 1'b0);
    @(posedge sys_clk);
    cmd_save <= 1'b1;
    @(posedge sys_clk);
    cmd_save <= 1'b0;
    #1;
    k = 0;
    while (cmd_ack !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(cmd_ack, 1'b1);
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 12; i++)
      chk(u_nvm.mem[i], shadow[i]);
    rd_all();
    $display("test save done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
